/* common/acm_pkg.sv */
package acm_pkg;

  // Printed offsets are not word aligned: they are indices, byte address is four times
  localparam logic [31:0] REG0_IDX = 32'hFFFFF200;
  localparam logic [31:0] REG1_IDX = 32'hFFFFF201;
  localparam logic [31:0] REG0_ADDR = REG0_IDX << 2;
  localparam logic [31:0] REG1_ADDR = REG1_IDX << 2;

  localparam logic [7:0] REG0_RST = 8'h00;
  localparam logic [7:0] REG1_RST = 8'h00;

  // Mode-enable register fields
  localparam int EN_BIT = 7;
  localparam int RUN_BIT = 6;
  localparam int BUF_BIT = 5;
  localparam int MODE_BIT = 4;

  // Timing-trigger register fields
  localparam int EDGE_HI = 7;
  localparam int EDGE_LO = 6;
  localparam int TRG_HI = 5;
  localparam int TRG_LO = 4;
  localparam int FR_HI = 3;
  localparam int FR_LO = 0;

  // Counts in main-clock cycles
  localparam int TMR_W = 12;
  localparam int CONV_UNIT_SHIFT = 7;
  localparam logic [TMR_W-1:0] CONV_UNIT_CYC = 12'h080;
  localparam logic [TMR_W-1:0] STAB_CYC_0 = 12'h040;
  localparam logic [TMR_W-1:0] STAB_CYC_1 = 12'h080;
  localparam logic [TMR_W-1:0] STAB_CYC_N = 12'h0A0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STAB = 2'b01,
    ST_TWAIT = 2'b10,
    ST_CONV = 2'b11
  } acm_st_t;

  typedef enum logic [1:0] {
    TRG_SW = 2'b00,
    TRG_TMR = 2'b01,
    TRG_EXT = 2'b10,
    TRG_BAD = 2'b11
  } acm_trg_t;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_RISE = 2'b10,
    EDGE_BOTH = 2'b11
  } acm_edge_t;

  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } acm_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } acm_axi_rsp_t;

  typedef struct packed {
    acm_st_t st;
    logic en;
    logic bsel;
    logic msel;
    logic [7:0] r1;
    logic pin_prev;
    logic stab_ok;
    logic trg_chg;
    logic run;
    logic busy;
    logic twait;
    logic start;
    logic done;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [31:0] waddr;
    logic [7:0] wbyte;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } acm_regs_t;

  localparam acm_regs_t REGS_RST = '{
    st: ST_IDLE,
    r1: REG1_RST,
    awready: 1'b1,
    wready: 1'b1,
    arready: 1'b1,
    default: '0
  };

endpackage

/* logic/acm_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module acm_timer
  import acm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [TMR_W-1:0] load_val_i,
  output logic expire_o
);

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic expire;
  } acm_tmr_t;

  acm_tmr_t q;
  acm_tmr_t d;

  // Expire stands in the last counted cycle, so the owner leaves its
  // state exactly load_val edges after the loading edge
  always_comb
  begin
    d = q;
    d.expire = 1'b0;
    if (load_i)
    begin
      d.cnt = load_val_i;
    end
    else if (q.cnt != '0)
    begin
      d.cnt = q.cnt - 1'b1;
      // Loads below two never expire; every load used is zero or far above
      d.expire = (q.cnt == 12'h002);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign expire_o = q.expire;

endmodule
`default_nettype wire

/* logic/acm_top.sv */
// Overview of operation
// RULE1 - Byte wide registers, status bit ignores writes
// RULE2 - Enable bit turns conversion on or off
// RULE3 - Status bit shows stopped or operating
// RULE4 - Buffer bit picks one or four buffers
// RULE5 - Mode bit picks scan or select
// RULE6 - Trigger modes wait until enable cleared
// RULE7 - Software start; mode switch enters wait at once
// RULE8 - Software keeps mode bits while enabled
// RULE9 - First register write restarts running conversion
// RULE10 - Second register write restarts running conversion
// RULE11 - Software keeps edge, time fields while enabled
// RULE12 - Conversion lasts 128 times code plus one
// RULE13 - Stabilization wait before first conversion only
// RULE14 - Trigger change and re-enable skips wait
// RULE15 - Software aims for two to ten microseconds
// RULE16 - Edge field picks none, fall, rise, both
// RULE17 - Source field picks software, timer, pin
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module acm_top
  import acm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire acm_axi_req_t axi_req_i,
  output acm_axi_rsp_t axi_rsp_o,
  input wire logic timer_trig_i,
  input wire logic external_conv_trigger_pin_i,
  output logic conv_start_o,
  output logic conv_done_o,
  output logic conv_busy_o,
  output logic trig_wait_o,
  output logic scan_or_select_choice_o,
  output logic buffer_count_select_o
);

  acm_regs_t q;
  acm_regs_t d;
  logic tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic tmr_expire;
  logic wr_go;
  logic hit0;
  logic hit1;
  logic w0;
  logic w1;
  logic en_n;
  logic [7:0] r1_n;
  logic [1:0] trg_n;
  logic [FR_HI:FR_LO] fr_n;
  logic rise;
  logic fall;
  logic trig_hit;
  logic trg_chg_now;
  logic [7:0] rd_byte;

  acm_timer acm_timer_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(tmr_load),
    .load_val_i(tmr_val),
    .expire_o(tmr_expire)
  );

  assign wr_go = q.aw_have & q.w_have;
  assign hit0 = (q.waddr == REG0_ADDR);
  assign hit1 = (q.waddr == REG1_ADDR);
  // Only lane 0 carries the byte; lanes 1..3 are ignored
  assign w0 = wr_go & hit0 & q.wstrb0; // [RULE1]
  assign w1 = wr_go & hit1 & q.wstrb0; // [RULE1]
  assign en_n = w0 ? q.wbyte[EN_BIT] : q.en; // [RULE2]
  assign r1_n = w1 ? q.wbyte : q.r1;
  assign trg_n = r1_n[TRG_HI:TRG_LO];
  assign fr_n = r1_n[FR_HI:FR_LO];
  assign trg_chg_now = w1 & (q.wbyte[TRG_HI:TRG_LO] != q.r1[TRG_HI:TRG_LO]);
  assign rise = external_conv_trigger_pin_i & ~q.pin_prev;
  assign fall = ~external_conv_trigger_pin_i & q.pin_prev;

  always_comb
  begin
    trig_hit = 1'b0;
    case (acm_trg_t'(q.r1[TRG_HI:TRG_LO])) // [RULE17]
      TRG_TMR: trig_hit = timer_trig_i;
      TRG_EXT:
      begin
        case (acm_edge_t'(q.r1[EDGE_HI:EDGE_LO])) // [RULE16]
          EDGE_FALL: trig_hit = fall;
          EDGE_RISE: trig_hit = rise;
          EDGE_BOTH: trig_hit = rise | fall;
          default: trig_hit = 1'b0;
        endcase
      end
      default: trig_hit = 1'b0;
    endcase
  end

  always_comb
  begin
    rd_byte = '0;
    if (axi_req_i.araddr == REG0_ADDR)
    begin
      rd_byte[EN_BIT] = q.en;
      rd_byte[RUN_BIT] = q.run; // [RULE3]
      rd_byte[BUF_BIT] = q.bsel;
      rd_byte[MODE_BIT] = q.msel;
    end
    else if (axi_req_i.araddr == REG1_ADDR)
    begin
      rd_byte = q.r1;
    end
  end

  always_comb
  begin
    d = q;
    d.start = 1'b0;
    d.done = 1'b0;
    d.pin_prev = external_conv_trigger_pin_i;
    tmr_load = 1'b0;
    tmr_val = '0;
    // Write channel: address and data taken in either order
    if (q.awready && axi_req_i.awvalid)
    begin
      d.awready = 1'b0;
      d.aw_have = 1'b1;
      d.waddr = axi_req_i.awaddr;
    end
    if (q.wready && axi_req_i.wvalid)
    begin
      d.wready = 1'b0;
      d.w_have = 1'b1;
      d.wbyte = axi_req_i.wdata[7:0];
      d.wstrb0 = axi_req_i.wstrb[0];
    end
    if (wr_go)
    begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = (hit0 | hit1) ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.bvalid && axi_req_i.bready)
    begin
      d.bvalid = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end
    // Read channel
    if (q.arready && axi_req_i.arvalid)
    begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rdata = {24'h000000, rd_byte};
      d.rresp = (axi_req_i.araddr == REG0_ADDR || axi_req_i.araddr == REG1_ADDR)
        ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.rvalid && axi_req_i.rready)
    begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end
    // Register fields; status bit has no write path
    if (w0)
    begin
      d.en = q.wbyte[EN_BIT]; // [RULE2]
      d.bsel = q.wbyte[BUF_BIT]; // [RULE4]
      d.msel = q.wbyte[MODE_BIT]; // [RULE5]
    end
    d.r1 = r1_n;
    if (trg_chg_now)
    begin
      d.trg_chg = 1'b1;
    end
    // Sequencer
    if (!en_n)
    begin
      d.st = ST_IDLE; // [RULE2]
      tmr_load = 1'b1;
    end
    else
    begin
      case (q.st)
        ST_IDLE:
        begin
          if (q.stab_ok && (q.trg_chg || trg_chg_now))
          begin
            d.st = (trg_n == TRG_SW) ? ST_CONV : ST_TWAIT; // [RULE14]
            d.trg_chg = 1'b0;
          end
          else
          begin
            d.st = ST_STAB; // [RULE13]
            tmr_load = 1'b1;
            case (fr_n)
              4'h0: tmr_val = STAB_CYC_0;
              4'h1: tmr_val = STAB_CYC_1;
              default: tmr_val = STAB_CYC_N;
            endcase
          end
        end
        ST_STAB:
        begin
          if (tmr_expire)
          begin
            d.stab_ok = 1'b1;
            // A source change in this very cycle still counts
            d.trg_chg = trg_chg_now;
            d.st = (trg_n == TRG_SW) ? ST_CONV : ST_TWAIT; // [RULE13]
          end
        end
        ST_TWAIT:
        begin
          if ((w0 || w1) && trg_n == TRG_SW)
          begin
            d.st = ST_CONV; // [RULE7]
          end
          else if (trig_hit)
          begin
            d.st = ST_CONV; // [RULE6]
          end
        end
        ST_CONV:
        begin
          if (w0 || w1)
          begin
            d.st = (trg_n == TRG_SW) ? ST_CONV : ST_TWAIT; // [RULE9] [RULE10] [RULE7]
            tmr_load = 1'b1;
          end
          else if (tmr_expire)
          begin
            d.done = 1'b1;
            // Software trigger keeps converting back to back
            d.st = (trg_n == TRG_SW) ? ST_CONV : ST_TWAIT; // [RULE6]
          end
        end
        default: d.st = ST_IDLE;
      endcase
      if (d.st == ST_CONV && (q.st != ST_CONV || (w0 || w1) || tmr_expire))
      begin
        d.start = 1'b1;
        tmr_load = 1'b1;
        tmr_val = TMR_W'({1'b0, fr_n} + 5'h01) << CONV_UNIT_SHIFT; // [RULE12]
      end
    end
    d.run = (d.st == ST_STAB) || (d.st == ST_CONV); // [RULE3]
    d.busy = (d.st == ST_CONV);
    d.twait = (d.st == ST_TWAIT);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= REGS_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign axi_rsp_o.awready = q.awready;
  assign axi_rsp_o.wready = q.wready;
  assign axi_rsp_o.bvalid = q.bvalid;
  assign axi_rsp_o.bresp = q.bresp;
  assign axi_rsp_o.arready = q.arready;
  assign axi_rsp_o.rvalid = q.rvalid;
  assign axi_rsp_o.rdata = q.rdata;
  assign axi_rsp_o.rresp = q.rresp;
  assign conv_start_o = q.start;
  assign conv_done_o = q.done;
  assign conv_busy_o = q.busy;
  assign trig_wait_o = q.twait;
  assign scan_or_select_choice_o = q.msel;
  assign buffer_count_select_o = q.bsel;

  // Cycle counters read only by the checks below
  logic [TMR_W-1:0] conv_cnt_q;
  logic [TMR_W-1:0] stab_cnt_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      conv_cnt_q <= '0;
      stab_cnt_q <= '0;
    end
    else
    begin
      conv_cnt_q <= conv_start_o ? 12'h001 : conv_cnt_q + 12'h001;
      stab_cnt_q <= (q.st == ST_STAB) ? stab_cnt_q + 12'h001 : '0;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_disable_write;
    w0 && !q.wbyte[EN_BIT];
  endsequence

  sequence s_restart_write;
    q.st == ST_CONV && (w0 || w1) && en_n && trg_n == TRG_SW;
  endsequence

  a_enable_off: assert property (s_disable_write |=> q.st == ST_IDLE && !conv_busy_o) // [RULE2]
    else $error("Clearing enable did not stop");
  a_status_read: assert property (q.arready && axi_req_i.arvalid
    && axi_req_i.araddr == REG0_ADDR |=> axi_rsp_o.rdata[RUN_BIT] == $past(q.run)) // [RULE1]
    else $error("Status bit read wrong");
  a_run_flag: assert property (q.run == (conv_busy_o || q.st == ST_STAB)) // [RULE3]
    else $error("Run flag disagrees with state");
  a_buf_mode: assert property (w0 |=> buffer_count_select_o == $past(q.wbyte[BUF_BIT])
    && scan_or_select_choice_o == $past(q.wbyte[MODE_BIT])) // [RULE4] [RULE5]
    else $error("Mode bits not stored");
  a_wait_hold: assert property (q.st == ST_TWAIT && en_n && trg_n != TRG_SW
    && !trig_hit |=> trig_wait_o) // [RULE6]
    else $error("Trigger wait left early");
  a_sw_switch: assert property (conv_busy_o && w1 && en_n && trg_n != TRG_SW
    |=> trig_wait_o && !conv_busy_o) // [RULE7]
    else $error("No immediate trigger wait");
  a_restart_conv: assert property (s_restart_write |=> conv_start_o ##1 conv_cnt_q == 12'h001)
    // [RULE9] [RULE10]
    else $error("Write did not restart conversion");
  a_conv_len: assert property (conv_done_o |-> conv_cnt_q ==
    TMR_W'({1'b0, q.r1[FR_HI:FR_LO]} + 5'h01) << CONV_UNIT_SHIFT) // [RULE12]
    else $error("Conversion length wrong");
  a_stab_len: assert property ($fell(q.st == ST_STAB) && q.en |-> $past(stab_cnt_q) + 12'h001 ==
    ((q.r1[FR_HI:FR_LO] == 4'h0) ? STAB_CYC_0 :
     (q.r1[FR_HI:FR_LO] == 4'h1) ? STAB_CYC_1 : STAB_CYC_N)) // [RULE13]
    else $error("Stabilization length wrong");
  a_skip_stab: assert property (q.st == ST_IDLE && w0 && q.wbyte[EN_BIT] && q.stab_ok
    && q.trg_chg |=> q.st != ST_STAB) // [RULE14]
    else $error("Needless stabilization wait");
  a_ext_edge: assert property (q.st == ST_TWAIT && en_n && !w0 && !w1
    && q.r1[TRG_HI:TRG_LO] == TRG_EXT && q.r1[EDGE_HI:EDGE_LO] == EDGE_RISE && rise
    |=> conv_start_o && conv_busy_o) // [RULE16]
    else $error("Rising edge did not start");
  a_timer_trig: assert property (q.st == ST_TWAIT && en_n && !w0 && !w1
    && q.r1[TRG_HI:TRG_LO] == TRG_TMR && timer_trig_i |=> conv_start_o) // [RULE17]
    else $error("Timer trigger did not start");

endmodule
`default_nettype wire

/* sim/acm_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module acm_top_tb
  import acm_pkg::*;
;
  logic clk_i;
  logic rst_i;
  acm_axi_req_t req;
  acm_axi_rsp_t rsp;
  logic tmr;
  logic pin;
  logic conv_start_o;
  logic conv_done_o;
  logic conv_busy_o;
  logic trig_wait_o;
  logic sel_o;
  logic buf_o;
  int n_fail;
  int check_count;

  acm_top acm_top_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .axi_req_i(req),
    .axi_rsp_o(rsp),
    .timer_trig_i(tmr),
    .external_conv_trigger_pin_i(pin),
    .conv_start_o(conv_start_o),
    .conv_done_o(conv_done_o),
    .conv_busy_o(conv_busy_o),
    .trig_wait_o(trig_wait_o),
    .scan_or_select_choice_o(sel_o),
    .buffer_count_select_o(buf_o)
  );

  acm_trig_src acm_trig_src_inst (
    .clk_i(clk_i),
    .timer_trig_o(tmr),
    .pin_o(pin)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bready and rready stay high throughout, so no strobe is lowered and raised in one step
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
    req.awaddr <= a;
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (rsp.awready === 1'b1)
        req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1)
        req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    chk({30'h0, rsp.bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] exp, input logic [1:0] er);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (rsp.arready === 1'b1)
        req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    chk(rsp.rdata, {24'h0, exp});
    chk({30'h0, rsp.rresp}, {30'h0, er});
  endtask

  function automatic logic pick(input int s);
    return s == 0 ? conv_start_o : s == 1 ? conv_done_o : trig_wait_o;
  endfunction

  task automatic upto(input int s, input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (pick(s) !== 1'b1 && n < lim);
  endtask

  initial
  begin
    int n;
    n_fail = 0;
    check_count = 0;
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    rst_i = 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(REG0_ADDR, 8'h00, RESP_OKAY);
    rd(REG1_ADDR, 8'h00, RESP_OKAY);
    rd(REG0_ADDR + 32'h8, 8'h00, RESP_SLVERR);
    wr(REG0_ADDR + 32'h8, 8'hFF, RESP_SLVERR);
    wr(REG0_ADDR, 8'hFF, RESP_OKAY);
    chk({31'h0, sel_o}, 32'h1);
    chk({31'h0, buf_o}, 32'h1);
    rd(REG0_ADDR, 8'hF0, RESP_OKAY);
    wr(REG0_ADDR, 8'h30, RESP_OKAY);
    rd(REG0_ADDR, 8'h30, RESP_OKAY);
    wr(REG0_ADDR, 8'h00, RESP_OKAY);
    chk({31'h0, sel_o}, 32'h0);
    for (int k = 0; k < 16; k++)
    begin
      wr(REG1_ADDR, {4'h0, k[3:0]}, RESP_OKAY);
      wr(REG0_ADDR, 8'h80, RESP_OKAY);
      upto(0, 400, n);
      chk(n, k == 0 ? 64 : k == 1 ? 128 : 160);
      upto(1, 4000, n);
      chk(n, 128 * (k + 1));
      upto(1, 4000, n);
      chk(n, 128 * (k + 1));
      wr(REG0_ADDR, 8'h00, RESP_OKAY);
      repeat (2) @(posedge clk_i);
      chk({31'h0, conv_busy_o}, 32'h0);
    end
    wr(REG1_ADDR, 8'h00, RESP_OKAY);
    wr(REG0_ADDR, 8'h80, RESP_OKAY);
    upto(0, 400, n);
    repeat (50) @(posedge clk_i);
    wr(REG1_ADDR, 8'h00, RESP_OKAY);
    upto(1, 4000, n);
    chk(32'(n >= 120 && n <= 128), 32'h1);
    repeat (50) @(posedge clk_i);
    wr(REG0_ADDR, 8'h80, RESP_OKAY);
    upto(1, 4000, n);
    chk(32'(n >= 120 && n <= 128), 32'h1);
    wr(REG1_ADDR, 8'h10, RESP_OKAY);
    upto(2, 4, n);
    chk({31'h0, trig_wait_o}, 32'h1);
    wr(REG0_ADDR, 8'hC0, RESP_OKAY);
    rd(REG0_ADDR, 8'h80, RESP_OKAY);
    acm_trig_src_inst.pulse_timer();
    upto(0, 4, n);
    chk(n, 1);
    upto(1, 4000, n);
    chk(n, 128);
    repeat (200) @(posedge clk_i);
    chk({31'h0, trig_wait_o}, 32'h1);
    wr(REG0_ADDR, 8'h00, RESP_OKAY);
    repeat (2) @(posedge clk_i);
    chk({31'h0, trig_wait_o}, 32'h0);
    for (int e = 0; e < 4; e++)
    begin
      wr(REG1_ADDR, {e[1:0], 6'h23}, RESP_OKAY);
      wr(REG0_ADDR, 8'h80, RESP_OKAY);
      upto(2, 600, n);
      acm_trig_src_inst.drive_pin(1'b1);
      upto(0, 3, n);
      chk(32'(n == 1), {31'h0, e[1]});
      upto(2, 600, n);
      acm_trig_src_inst.drive_pin(1'b0);
      upto(0, 3, n);
      chk(32'(n == 1), {31'h0, e[0]});
      upto(2, 600, n);
      wr(REG0_ADDR, 8'h00, RESP_OKAY);
    end
    wr(REG1_ADDR, 8'hF0, RESP_OKAY);
    wr(REG0_ADDR, 8'h80, RESP_OKAY);
    acm_trig_src_inst.pulse_timer();
    acm_trig_src_inst.drive_pin(1'b1);
    upto(0, 20, n);
    chk(n, 20);
    acm_trig_src_inst.drive_pin(1'b0);
    wr(REG0_ADDR, 8'h00, RESP_OKAY);
    wr(REG1_ADDR, 8'h00, RESP_OKAY);
    wr(REG0_ADDR, 8'h80, RESP_OKAY);
    // Start pulse is already past when the write returns; a skipped
    // wait shows as one plain conversion length to the first done
    upto(1, 400, n);
    chk(n, 128);
    close_out();
  end

  // Whole run needs about 41000 cycles
  initial
  begin
    repeat (100000) @(posedge clk_i);
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire

/* sim/acm_trig_src.sv */
`timescale 1ns/10ps
`default_nettype none
module acm_trig_src
(
  input wire logic clk_i,
  output logic timer_trig_o,
  output logic pin_o
);
  initial
  begin
    timer_trig_o = 1'b0;
    pin_o = 1'b0;
  end

  // Timer event lasts one cycle, like a compare match
  task automatic pulse_timer();
    timer_trig_o <= 1'b1;
    @(posedge clk_i);
    timer_trig_o <= 1'b0;
  endtask

  // Pin holds its level, so edges are spaced a cycle apart at least
  task automatic drive_pin(input logic v);
    pin_o <= v;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire
